// ==== mcl_pkg.sv ====
// Constants and types for the media converter loopback and status block.
// Assumes one 125 MHz system clock and an 8-bit register port.
package mcl_pkg;
    localparam int          CLK_MHZ      = 125;
    localparam int          LOOP_TMO_US  = 100;
    localparam int          LOOP_TMO_CYC = LOOP_TMO_US * CLK_MHZ;
    localparam int          TMO_W        = 16;
    localparam logic [7:0]  A_LOOP_LOC   = 8'h0b;
    localparam logic [7:0]  A_MC_FIRST   = 8'h40;
    localparam logic [7:0]  A_MC_LAST    = 8'h5f;
    localparam logic [7:0]  A_CNT_CRC    = 8'h48;
    localparam logic [7:0]  A_CNT_TMO    = 8'h49;
    localparam logic [7:0]  A_CNT_GOOD   = 8'h4a;
    localparam logic [7:0]  A_CNT_TX     = 8'h4b;
    localparam logic [7:0]  A_CNT_RX     = 8'h4c;
    localparam logic [7:0]  A_LSTAT_LO   = 8'h4d;
    localparam logic [7:0]  A_LSTAT_HI   = 8'h4e;
    localparam logic [7:0]  A_PSTAT_LO   = 8'h4f;
    localparam logic [7:0]  A_PSTAT_HI   = 8'h50;
    localparam logic [7:0]  A_LID_FIRST  = 8'h51;
    localparam logic [7:0]  A_LID_LAST   = 8'h56;
    localparam logic [7:0]  A_PID_FIRST  = 8'h57;
    localparam logic [7:0]  A_PID_LAST   = 8'h5c;
    localparam logic [7:0]  A_IRQ_STAT   = 8'h5d;
    localparam logic [7:0]  A_IRQ_MASK   = 8'h5e;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam int          LOC_LSB      = 2;
    localparam logic [1:0]  LOC_STRAP    = 2'b00;
    localparam logic [1:0]  LOC_P1       = 2'b01;
    localparam logic [1:0]  LOC_P2MAC    = 2'b10;
    localparam logic [1:0]  LOC_P2LINE   = 2'b11;
    localparam int          S_PWR        = 0;
    localparam int          S_OPT        = 1;
    localparam int          S_UTP        = 2;
    localparam int          S_MC         = 3;
    localparam int          S_LOOP       = 5;
    localparam int          S_TERM       = 6;
    localparam int          IRQ_LSTART   = 0;
    localparam int          IRQ_LSTOP    = 1;
    localparam int          IRQ_IND      = 2;
    localparam int          IRQ_TMO      = 3;
    typedef enum logic [1:0] {
        MCL_NORMAL   = 2'b00,
        MCL_CENTER   = 2'b01,
        MCL_TERM_NO3 = 2'b10,
        MCL_TERM_P3  = 2'b11
    } mcl_mode_t;
    typedef enum logic [1:0] {
        MCL_PATH_OFF  = 2'b00,
        MCL_PATH_P1   = 2'b01,
        MCL_PATH_MAC  = 2'b10,
        MCL_PATH_LINE = 2'b11
    } mcl_path_t;
endpackage

// ==== mcl_loopback_status.sv ====
// Terminal side loopback steering, fault pin and indication requests.
// Assumes OAM framing lives outside; streams are byte wide, one clock.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Optical loop turns fiber frames at port 1
// [R2] MAC loop turns fiber frames at port 2 MAC
// [R3] Line loop turns fiber frames at port 2 PHY
// [R4] Returned frames always leave on fiber transmit
// [R5] Thirty-two converter registers at 0x40 to 0x5F
// [R6] Count CRC errors, timeouts, good loop frames
// [R7] Count OAM frames; show status, vendor, model
// [R8] Two mode pins pick center or terminal
// [R9] Mode pair decodes normal, center, two terminal
// [R10] Center side starts and stops each loop
// [R11] Power-down fall requests indication, S0 set
// [R12] Fault pin low on fault, partner down, loop
// [R13] Filter strap high drops errored and OAM frames
// [R14] Filter strap low drops only OAM frames
// [R15] Location strap picks port 1 or port 2
// [R16] Missing link strap enables that feature
// [R17] Diagnostic change requests indication, S3 follows pin
// [R18] S0 is one during power down
// [R19] Straps caught once after reset release
module mcl_loopback_status #(
    parameter int          LOOP_TMO_CYC = mcl_pkg::LOOP_TMO_CYC,
    parameter logic [23:0] VENDOR_CODE  = 24'h3c5a01, // Arbitrary value
    parameter logic [23:0] MODEL_NUM    = 24'h000a10  // Arbitrary value
)(
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_irq,
    input  wire logic        i_mc_mode_sel_hi,
    input  wire logic        i_mc_mode_sel_lo,
    input  wire logic        i_loop_err_filter_strap,
    input  wire logic        i_loop_location_strap,
    input  wire logic        i_missing_link_strap,
    input  wire logic        i_power_down_detect_n,
    input  wire logic        i_diag_fail_in,
    input  wire logic        i_far_end_fault,
    input  wire logic        i_partner_fiber_down,
    input  wire logic        i_partner_copper_down,
    input  wire logic        i_utp_link_down,
    input  wire logic        i_loop_start,
    input  wire logic        i_loop_stop,
    input  wire logic        i_oam_tx_done,
    input  wire logic        i_oam_rx_ok,
    input  wire logic [15:0] i_partner_status,
    input  wire logic [47:0] i_partner_id,
    output logic             o_ind_req,
    output logic      [15:0] o_ind_status,
    output logic             o_fiber_fault_ind_n,
    output logic      [1:0]  o_mc_mode,
    output logic             o_port3_en,
    output logic             o_missing_link_en,
    output logic             o_loop_active,
    input  wire logic [7:0]  i_fiber_rx_pair_data,
    input  wire logic        i_fiber_rx_pair_vld,
    input  wire logic        i_fiber_rx_pair_sop,
    input  wire logic        i_fiber_rx_pair_eop,
    input  wire logic        i_fiber_rx_pair_crc_err,
    input  wire logic        i_fiber_rx_pair_len_err,
    input  wire logic        i_fiber_rx_pair_oam,
    input  wire logic [7:0]  i_p2_ret_data,
    input  wire logic        i_p2_ret_vld,
    input  wire logic        i_p2_ret_sop,
    input  wire logic        i_p2_ret_eop,
    input  wire logic [7:0]  i_sw_tx_data,
    input  wire logic        i_sw_tx_vld,
    input  wire logic        i_sw_tx_sop,
    input  wire logic        i_sw_tx_eop,
    output logic      [7:0]  o_fiber_tx_pair_data,
    output logic             o_fiber_tx_pair_vld,
    output logic             o_fiber_tx_pair_sop,
    output logic             o_fiber_tx_pair_eop,
    output logic             o_fiber_tx_pair_drop,
    output logic      [7:0]  o_p2_loop_data,
    output logic             o_p2_loop_vld,
    output logic             o_p2_loop_sop,
    output logic             o_p2_loop_eop,
    output logic             o_p2_loop_drop,
    output logic      [1:0]  o_p2_loop_sel
);
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] id_byte(input logic [47:0] v, input logic [7:0] off);
        id_byte = v[off[2:0] * 8 +: 8];
    endfunction

    // Strap capture group
    logic                straps_done_r, straps_done_nxt;
    mcl_pkg::mcl_mode_t  mode_r, mode_nxt;
    logic                filt_r, filt_nxt;
    logic                loc_r, loc_nxt;
    logic                ml_r, ml_nxt;
    logic                is_term;

    // Straps sampled on first edge out of reset
    always_comb
    begin
        straps_done_nxt = 1'b1;
        mode_nxt = mode_r;
        filt_nxt = filt_r;
        loc_nxt = loc_r;
        ml_nxt = ml_r;
        if (!straps_done_r)
        begin
            mode_nxt = mcl_pkg::mcl_mode_t'({i_mc_mode_sel_hi, i_mc_mode_sel_lo}); // [R8] [R19]
            filt_nxt = i_loop_err_filter_strap; // [R19]
            loc_nxt  = i_loop_location_strap;
            ml_nxt   = i_missing_link_strap;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            straps_done_r <= 1'b0;
            mode_r <= mcl_pkg::MCL_NORMAL;
            filt_r <= 1'b0;
            loc_r <= 1'b0;
            ml_r <= 1'b0;
        end
        else
        begin
            straps_done_r <= straps_done_nxt;
            mode_r <= mode_nxt;
            filt_r <= filt_nxt;
            loc_r <= loc_nxt;
            ml_r <= ml_nxt;
        end
    end

    assign is_term           = (mode_r == mcl_pkg::MCL_TERM_NO3) || (mode_r == mcl_pkg::MCL_TERM_P3); // [R9]
    assign o_mc_mode         = mode_r;
    assign o_port3_en        = (mode_r != mcl_pkg::MCL_TERM_NO3); // [R9]
    assign o_missing_link_en = is_term && ml_r; // [R16]

    // Main state group
    logic [7:0]                 regs_r [32];
    logic [7:0]                 regs_nxt [32];
    logic [7:0]                 loc_reg_r, loc_reg_nxt;
    logic [7:0]                 cnt_crc_r, cnt_crc_nxt, cnt_tmo_r, cnt_tmo_nxt, cnt_good_r, cnt_good_nxt;
    logic [7:0]                 cnt_tx_r, cnt_tx_nxt, cnt_rx_r, cnt_rx_nxt;
    logic [7:0]                 irq_r, irq_nxt, rdata_r, rdata_nxt;
    logic [mcl_pkg::TMO_W-1:0]  tmo_r, tmo_nxt;
    logic                       loop_r, loop_nxt, pdd_q_r, diag_q_r, ind_r, ind_nxt, fault_n_r, fault_n_nxt;
    logic [15:0]                stat_r, stat_now;
    logic [7:0]                 ftx_d_r, ftx_d_nxt, p2_d_r, p2_d_nxt;
    logic [3:0]                 ftx_c_r, ftx_c_nxt, p2_c_r, p2_c_nxt;
    logic [1:0]                 sel_r, sel_nxt;
    mcl_pkg::mcl_path_t         path;
    logic                       rx_pass, rx_drop;
    logic [7:0]                 rval;
    logic [7:0]                 mask;

    always_comb
    begin
        case (loc_reg_r[mcl_pkg::LOC_LSB +: 2]) // [R15]
            mcl_pkg::LOC_P1:     path = mcl_pkg::MCL_PATH_P1;
            mcl_pkg::LOC_P2MAC:  path = mcl_pkg::MCL_PATH_MAC;
            mcl_pkg::LOC_P2LINE: path = mcl_pkg::MCL_PATH_LINE;
            default:             path = loc_r ? mcl_pkg::MCL_PATH_P1 : mcl_pkg::MCL_PATH_MAC;
        endcase
    end

    assign mask = regs_r[mcl_pkg::A_IRQ_MASK[4:0]];

    always_comb
    begin
        stat_now                  = 16'h0000;
        stat_now[mcl_pkg::S_PWR]  = !i_power_down_detect_n; // [R18]
        stat_now[mcl_pkg::S_OPT]  = i_far_end_fault;
        stat_now[mcl_pkg::S_UTP]  = i_utp_link_down;
        stat_now[mcl_pkg::S_MC]   = i_diag_fail_in; // [R17]
        stat_now[mcl_pkg::S_LOOP] = loop_r;
        stat_now[mcl_pkg::S_TERM] = is_term;
    end

    // Counters and status overlay plain storage
    always_comb
    begin
        rval = mcl_pkg::RST_BYTE;
        if (i_reg_addr == mcl_pkg::A_LOOP_LOC)
            rval = loc_reg_r;
        else if (in_range(i_reg_addr, mcl_pkg::A_LID_FIRST, mcl_pkg::A_LID_LAST))
            rval = id_byte({MODEL_NUM, VENDOR_CODE}, i_reg_addr - mcl_pkg::A_LID_FIRST); // [R7]
        else if (in_range(i_reg_addr, mcl_pkg::A_PID_FIRST, mcl_pkg::A_PID_LAST))
            rval = id_byte(i_partner_id, i_reg_addr - mcl_pkg::A_PID_FIRST); // [R7]
        else if (in_range(i_reg_addr, mcl_pkg::A_MC_FIRST, mcl_pkg::A_MC_LAST)) // [R5]
        begin
            case (i_reg_addr)
                mcl_pkg::A_CNT_CRC:  rval = cnt_crc_r; // [R6]
                mcl_pkg::A_CNT_TMO:  rval = cnt_tmo_r;
                mcl_pkg::A_CNT_GOOD: rval = cnt_good_r;
                mcl_pkg::A_CNT_TX:   rval = cnt_tx_r; // [R7]
                mcl_pkg::A_CNT_RX:   rval = cnt_rx_r;
                mcl_pkg::A_LSTAT_LO: rval = stat_r[7:0];
                mcl_pkg::A_LSTAT_HI: rval = stat_r[15:8];
                mcl_pkg::A_PSTAT_LO: rval = i_partner_status[7:0];
                mcl_pkg::A_PSTAT_HI: rval = i_partner_status[15:8];
                mcl_pkg::A_IRQ_STAT: rval = irq_r;
                default:             rval = regs_r[i_reg_addr[4:0]];
            endcase
        end
    end

    assign rx_pass = loop_r && i_fiber_rx_pair_vld && !i_fiber_rx_pair_oam; // [R13] [R14]
    assign rx_drop = filt_r && i_fiber_rx_pair_eop && (i_fiber_rx_pair_crc_err || i_fiber_rx_pair_len_err); // [R13]

    always_comb
    begin
        regs_nxt = regs_r;
        loc_reg_nxt = loc_reg_r;
        cnt_crc_nxt = cnt_crc_r;
        cnt_tmo_nxt = cnt_tmo_r;
        cnt_good_nxt = cnt_good_r;
        cnt_tx_nxt = cnt_tx_r + 8'h01 * i_oam_tx_done; // [R7]
        cnt_rx_nxt = cnt_rx_r + 8'h01 * i_oam_rx_ok;
        tmo_nxt = tmo_r;
        irq_nxt = irq_r;
        rdata_nxt = i_reg_rd ? rval : mcl_pkg::RST_BYTE;
        loop_nxt = loop_r;
        ftx_d_nxt = i_sw_tx_data;
        ftx_c_nxt = {i_sw_tx_vld, i_sw_tx_sop, i_sw_tx_eop, 1'b0};
        p2_d_nxt = i_fiber_rx_pair_data;
        p2_c_nxt = 4'h0;
        sel_nxt = mcl_pkg::MCL_PATH_OFF;
        if (i_reg_wr && in_range(i_reg_addr, mcl_pkg::A_MC_FIRST, mcl_pkg::A_MC_LAST)) // [R5]
            regs_nxt[i_reg_addr[4:0]] = i_reg_wdata;
        if (i_reg_wr && (i_reg_addr == mcl_pkg::A_LOOP_LOC))
            loc_reg_nxt = i_reg_wdata;
        // Center side owns the loop
        if (!is_term)
            loop_nxt = 1'b0;
        else if (i_loop_start) // [R10]
            loop_nxt = 1'b1;
        else if (i_loop_stop)
            loop_nxt = 1'b0;
        // No buffer, so errored frames are marked at eop
        if (loop_r)
        begin
            if (path == mcl_pkg::MCL_PATH_P1)
            begin
                ftx_d_nxt = i_fiber_rx_pair_data; // [R1] [R4]
                ftx_c_nxt = {rx_pass, i_fiber_rx_pair_sop, i_fiber_rx_pair_eop, rx_drop};
            end
            else
            begin
                sel_nxt   = path; // [R2] [R3]
                p2_c_nxt  = {rx_pass, i_fiber_rx_pair_sop, i_fiber_rx_pair_eop, rx_drop};
                ftx_d_nxt = i_p2_ret_data; // [R4]
                ftx_c_nxt = {i_p2_ret_vld, i_p2_ret_sop, i_p2_ret_eop, 1'b0};
                if (rx_pass && i_fiber_rx_pair_eop && !rx_drop)
                    tmo_nxt = LOOP_TMO_CYC[mcl_pkg::TMO_W-1:0];
            end
            if (rx_pass && i_fiber_rx_pair_eop) // [R6]
            begin
                if (i_fiber_rx_pair_crc_err)
                    cnt_crc_nxt = cnt_crc_r + 8'h01;
                else if (!i_fiber_rx_pair_len_err)
                    cnt_good_nxt = cnt_good_r + 8'h01;
            end
        end
        else
            tmo_nxt = '0;
        // Return before expiry stops the timer
        if (i_p2_ret_vld && i_p2_ret_eop && (tmo_r != '0))
            tmo_nxt = '0;
        else if (tmo_r != '0 && tmo_nxt == tmo_r)
            tmo_nxt = tmo_r - 1'b1;
        if (i_reg_rd && (i_reg_addr == mcl_pkg::A_IRQ_STAT))
            irq_nxt = mcl_pkg::RST_BYTE;
        if (tmo_nxt == '0 && tmo_r == 1'b1)
        begin
            cnt_tmo_nxt                = cnt_tmo_r + 8'h01; // [R6]
            irq_nxt[mcl_pkg::IRQ_TMO]  = 1'b1;
        end
        irq_nxt[mcl_pkg::IRQ_LSTART] = irq_nxt[mcl_pkg::IRQ_LSTART] | (loop_nxt && !loop_r);
        irq_nxt[mcl_pkg::IRQ_LSTOP]  = irq_nxt[mcl_pkg::IRQ_LSTOP] | (!loop_nxt && loop_r);
        irq_nxt[mcl_pkg::IRQ_IND]    = irq_nxt[mcl_pkg::IRQ_IND] | ind_nxt;
    end

    assign ind_nxt     = is_term && ((pdd_q_r && !i_power_down_detect_n) || (diag_q_r != i_diag_fail_in)); // [R11] [R17]
    assign fault_n_nxt = !(i_far_end_fault || i_partner_fiber_down || i_partner_copper_down || loop_r); // [R12]

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < 32; i++)
                regs_r[i] <= '0;
            loc_reg_r <= '0;
            cnt_crc_r <= '0;
            cnt_tmo_r <= '0;
            cnt_good_r <= '0;
            cnt_tx_r <= '0;
            cnt_rx_r <= '0;
            irq_r <= '0;
            rdata_r <= '0;
            tmo_r <= '0;
            loop_r <= 1'b0;
            pdd_q_r <= 1'b1;
            diag_q_r <= 1'b0;
            ind_r <= 1'b0;
            stat_r <= '0;
            fault_n_r <= 1'b1;
            ftx_d_r <= '0;
            ftx_c_r <= '0;
            p2_d_r <= '0;
            p2_c_r <= '0;
            sel_r <= mcl_pkg::MCL_PATH_OFF;
        end
        else
        begin
            regs_r <= regs_nxt;
            loc_reg_r <= loc_reg_nxt;
            cnt_crc_r <= cnt_crc_nxt;
            cnt_tmo_r <= cnt_tmo_nxt;
            cnt_good_r <= cnt_good_nxt;
            cnt_tx_r <= cnt_tx_nxt;
            cnt_rx_r <= cnt_rx_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            tmo_r <= tmo_nxt;
            loop_r <= loop_nxt;
            pdd_q_r <= i_power_down_detect_n;
            diag_q_r <= i_diag_fail_in;
            ind_r <= ind_nxt;
            stat_r <= stat_now;
            fault_n_r <= fault_n_nxt;
            ftx_d_r <= ftx_d_nxt;
            ftx_c_r <= ftx_c_nxt;
            p2_d_r <= p2_d_nxt;
            p2_c_r <= p2_c_nxt;
            sel_r <= sel_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_irq = |(irq_r & mask);
    assign o_ind_req = ind_r;
    assign o_ind_status = stat_r;
    assign o_fiber_fault_ind_n = fault_n_r;
    assign o_loop_active = loop_r;
    assign o_fiber_tx_pair_data = ftx_d_r;
    assign {o_fiber_tx_pair_vld, o_fiber_tx_pair_sop, o_fiber_tx_pair_eop, o_fiber_tx_pair_drop} = ftx_c_r;
    assign o_p2_loop_data = p2_d_r;
    assign {o_p2_loop_vld, o_p2_loop_sop, o_p2_loop_eop, o_p2_loop_drop} = p2_c_r;
    assign o_p2_loop_sel = sel_r;

    default clocking dclk @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    a_fault_loop: assert property (
        loop_r |=> !o_fiber_fault_ind_n) else $error("fault pin high in loop"); // [R12]
    a_pdd_ind: assert property (
        is_term && pdd_q_r && !i_power_down_detect_n |=> o_ind_req && o_ind_status[0])
        else $error("no power-down indication"); // [R11] [R18]
    a_diag_ind: assert property (
        is_term && (diag_q_r != i_diag_fail_in) |=> o_ind_req && (o_ind_status[3] == $past(i_diag_fail_in)))
        else $error("no diagnostic indication"); // [R17]
    a_p1_turn: assert property (
        rx_pass && path == mcl_pkg::MCL_PATH_P1 |=> o_fiber_tx_pair_vld
        && o_fiber_tx_pair_data == $past(i_fiber_rx_pair_data)) else $error("optical loop lost byte"); // [R1] [R4]
    a_p2_turn: assert property (
        rx_pass && path != mcl_pkg::MCL_PATH_P1 |=> o_p2_loop_vld && o_p2_loop_sel == $past(path))
        else $error("port 2 loop not steered"); // [R2] [R3]
    a_ret_fiber: assert property (
        loop_r && path != mcl_pkg::MCL_PATH_P1 && i_p2_ret_vld |=> o_fiber_tx_pair_vld)
        else $error("return not on fiber"); // [R4]
    a_oam_drop: assert property (
        i_fiber_rx_pair_oam |=> !o_p2_loop_vld) else $error("OAM frame looped"); // [R14]
    a_err_mark: assert property (
        rx_pass && i_fiber_rx_pair_eop && i_fiber_rx_pair_crc_err |=> (o_fiber_tx_pair_drop || o_p2_loop_drop) == filt_r)
        else $error("errored frame handling wrong"); // [R13] [R14]
    a_good_cnt: assert property (
        rx_pass && i_fiber_rx_pair_eop && !i_fiber_rx_pair_crc_err && !i_fiber_rx_pair_len_err
        |=> cnt_good_r == $past(cnt_good_r) + 8'h01) else $error("good count missed"); // [R6]
    a_strap_hold: assert property (
        straps_done_r |=> $stable(filt_r) && $stable(loc_r) && $stable(mode_r)) else $error("strap moved"); // [R19]
    a_mode_p3: assert property (
        $rose(straps_done_r) && $past(i_mc_mode_sel_hi) && !$past(i_mc_mode_sel_lo) |-> !o_port3_en)
        else $error("port 3 not disabled"); // [R9]
endmodule

// ==== mcl_center_model.sv ====
// Center converter model: loop commands and frames toward the fiber receive side.
// Assumes the terminal block samples everything on the rising edge of i_sys_clk.
`timescale 1ns/10ps
module mcl_center_model (
    input  wire logic       i_sys_clk,
    output logic            o_start,
    output logic            o_stop,
    output logic      [7:0] o_data,
    output logic            o_vld,
    output logic            o_sop,
    output logic            o_eop,
    output logic            o_crc,
    output logic            o_len,
    output logic            o_oam
);
    initial {o_start, o_stop, o_data, o_vld, o_sop, o_eop, o_crc, o_len, o_oam} = '0;
    task cmd(input logic go); // Loops are opened and closed only from here
        @(posedge i_sys_clk);
        o_start <= go;
        o_stop  <= !go;
        @(posedge i_sys_clk);
        o_start <= 1'b0;
        o_stop  <= 1'b0;
    endtask
    task frame(input int n, input logic crc, input logic len, input logic oam);
        for (int i = 0; i < n; i++)
        begin
            @(posedge i_sys_clk);
            o_data <= 8'h30 + 8'(i);
            {o_vld, o_sop, o_eop, o_oam} <= {1'b1, i == 0, i == n - 1, oam};
            {o_crc, o_len} <= (i == n - 1) ? {crc, len} : 2'b00;
        end
        @(posedge i_sys_clk);
        {o_vld, o_sop, o_eop, o_crc, o_len, o_oam} <= '0;
        o_data <= ~o_data; // Idle line never shows the last byte
    endtask
endmodule

// ==== media_converter_loopback_status_bench.sv ====
// Self-checking bench for the loopback steering, fault pin and indications.
// Assumes the center model drives fiber receive; port 2 return is driven here.
`timescale 1ns/10ps
module media_converter_loopback_status_bench;
    logic i_sys_clk, i_srst, i_reg_wr, i_reg_rd, i_mc_mode_sel_hi, i_mc_mode_sel_lo, i_loop_err_filter_strap;
    logic i_loop_location_strap, i_missing_link_strap, i_power_down_detect_n, i_diag_fail_in, i_oam_tx_done;
    logic i_p2_ret_vld, i_p2_ret_sop, i_p2_ret_eop, o_irq, o_ind_req, o_fiber_fault_ind_n, o_port3_en;
    logic o_missing_link_en, o_loop_active, tx_vld, tx_eop, tx_drp, p2_vld, p2_eop, p2_drp, tx_drop, p2_drop;
    logic [7:0]  i_reg_addr, i_reg_wdata, i_p2_ret_data, o_reg_rdata, n_tx = 0, n_p2 = 0, n_ind = 0;
    logic [15:0] o_ind_status, ind_st;
    logic [1:0]  o_mc_mode, o_p2_loop_sel;
    logic [3:0]  flt;
    logic [10:0] sw;
    wire logic   st, sp, rv, rs, re, rc, rl, ro;
    wire logic [7:0] rd8;
    int num_errors = 0;
    int total_checks = 0;
    localparam logic [16:0] ROWS [13] = '{17'h141a5, 17'h041a5, 17'h15f3c, 17'h05f3c, 17'h16011, 17'h06000,
        17'h05156, 17'h054cd, 17'h057a7, 17'h04f02, 17'h04b01, 17'h04c01, 17'h04800};
    mcl_center_model center (.i_sys_clk, .o_start(st), .o_stop(sp), .o_data(rd8), .o_vld(rv), .o_sop(rs),
        .o_eop(re), .o_crc(rc), .o_len(rl), .o_oam(ro));
    mcl_loopback_status #(.LOOP_TMO_CYC(20), .VENDOR_CODE(24'h123456), .MODEL_NUM(24'h00abcd)) dut ( // Arbitrary
        .i_sys_clk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_irq,
        .i_mc_mode_sel_hi, .i_mc_mode_sel_lo, .i_loop_err_filter_strap, .i_loop_location_strap,
        .i_missing_link_strap, .i_power_down_detect_n, .i_diag_fail_in, .i_far_end_fault(flt[0]),
        .i_partner_fiber_down(flt[1]), .i_partner_copper_down(flt[2]), .i_utp_link_down(flt[3]),
        .i_loop_start(st), .i_loop_stop(sp), .i_oam_tx_done, .i_oam_rx_ok(i_oam_tx_done), .i_partner_status(16'h0302),
        .i_partner_id(48'ha7), .o_ind_req, .o_ind_status, .o_fiber_fault_ind_n, .o_mc_mode, .o_port3_en,
        .o_missing_link_en, .o_loop_active, .i_fiber_rx_pair_data(rd8), .i_fiber_rx_pair_vld(rv),
        .i_fiber_rx_pair_sop(rs), .i_fiber_rx_pair_eop(re), .i_fiber_rx_pair_crc_err(rc),
        .i_fiber_rx_pair_len_err(rl), .i_fiber_rx_pair_oam(ro), .i_p2_ret_data, .i_p2_ret_vld, .i_p2_ret_sop,
        .i_p2_ret_eop, .i_sw_tx_data(sw[7:0]), .i_sw_tx_vld(sw[10]), .i_sw_tx_sop(sw[9]), .i_sw_tx_eop(sw[8]),
        .o_fiber_tx_pair_data(), .o_fiber_tx_pair_vld(tx_vld), .o_fiber_tx_pair_sop(),
        .o_fiber_tx_pair_eop(tx_eop), .o_fiber_tx_pair_drop(tx_drp), .o_p2_loop_data(), .o_p2_loop_vld(p2_vld),
        .o_p2_loop_sop(), .o_p2_loop_eop(p2_eop), .o_p2_loop_drop(p2_drp), .o_p2_loop_sel);
    // Tally stream output so checks need no cycle-exact alignment
    always @(posedge i_sys_clk)
    begin
        if (tx_vld === 1'b1) n_tx <= n_tx + 8'h01;
        if (p2_vld === 1'b1) n_p2 <= n_p2 + 8'h01;
        if (o_ind_req === 1'b1) {n_ind, ind_st} <= {n_ind + 8'h01, o_ind_status};
        if (tx_vld === 1'b1 && tx_eop === 1'b1) tx_drop <= tx_drp;
        if (p2_vld === 1'b1 && p2_eop === 1'b1) p2_drop <= p2_drp;
    end
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_sys_clk) i_reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk) {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        @(posedge i_sys_clk) i_reg_rd <= 1'b0;
        #1 chk("rdata", 16'(e), 16'(o_reg_rdata));
    endtask
    task ret(input int n);
        for (int i = 0; i < n; i++)
            @(posedge i_sys_clk) {i_p2_ret_data, i_p2_ret_vld, i_p2_ret_sop, i_p2_ret_eop} <= {8'(i), 1'b1, i == 0, i == n - 1};
        @(posedge i_sys_clk) {i_p2_ret_vld, i_p2_ret_sop, i_p2_ret_eop} <= '0;
    endtask
    task rst(input logic [4:0] s);
        @(posedge i_sys_clk) i_srst <= 1'b1;
        {i_mc_mode_sel_hi, i_mc_mode_sel_lo, i_loop_err_filter_strap, i_loop_location_strap, i_missing_link_strap} <= s;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        w(3);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        num_errors++; // Hang guard
        report_and_stop;
    end
    initial
    begin
        {i_srst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_power_down_detect_n, i_diag_fail_in} = 21'h100002;
        {i_oam_tx_done, i_p2_ret_data, i_p2_ret_vld, i_p2_ret_sop, i_p2_ret_eop, flt, sw} = '0;
        {i_mc_mode_sel_hi, i_mc_mode_sel_lo, i_loop_err_filter_strap, i_loop_location_strap, i_missing_link_strap} = '0;
        rst(5'b10111);
        chk("fault_n", 1, 16'(o_fiber_fault_ind_n));
        chk("mode", 2'b10, 16'(o_mc_mode));
        chk("port3_en", 0, 16'(o_port3_en));
        chk("missing_link_strap", 1, 16'(o_missing_link_en));
        @(posedge i_sys_clk) {i_mc_mode_sel_hi, i_mc_mode_sel_lo} <= 2'b01;
        w(2);
        chk("mode held", 2'b10, 16'(o_mc_mode));
        @(posedge i_sys_clk) i_oam_tx_done <= 1'b1;
        @(posedge i_sys_clk) i_oam_tx_done <= 1'b0;
        foreach (ROWS[k])
            if (ROWS[k][16]) wr(ROWS[k][15:8], ROWS[k][7:0]);
            else rd(ROWS[k][15:8], ROWS[k][7:0]);
        for (int b = 0; b < 4; b++)
        begin
            @(posedge i_sys_clk) flt <= 4'(1 << b);
            w(2);
            chk("fault_n on", 16'(b == 3), 16'(o_fiber_fault_ind_n));
            @(posedge i_sys_clk) flt <= 4'b0000;
            w(2);
            chk("fault_n off", 1, 16'(o_fiber_fault_ind_n));
        end
        @(posedge i_sys_clk) sw <= 11'h7a5;
        @(posedge i_sys_clk) sw <= '0;
        w(2);
        chk("sw tx", 1, 16'(n_tx));
        wr(8'h5e, 8'h01);
        center.cmd(1'b1);
        w(2);
        chk("irq", 1, 16'(o_irq));
        chk("loop", 1, 16'(o_loop_active));
        chk("loop fault_n", 0, 16'(o_fiber_fault_ind_n));
        center.frame(4, 1, 0, 0);
        center.frame(3, 0, 1, 0);
        w(3);
        chk("tx bytes", 8, 16'(n_tx));
        chk("tx drop", 1, 16'(tx_drop));
        center.frame(2, 0, 0, 1);
        center.frame(2, 0, 0, 0);
        w(3);
        chk("tx bytes", 10, 16'(n_tx));
        chk("tx drop", 0, 16'(tx_drop));
        rd(8'h48, 8'h01);
        rd(8'h4a, 8'h01);
        rd(8'h5d, 8'h01);
        chk("irq clear", 0, 16'(o_irq));
        wr(8'h0b, 8'h08);
        center.frame(3, 0, 0, 0);
        w(3);
        chk("p2 bytes", 3, 16'(n_p2));
        chk("p2 sel", 2'b10, 16'(o_p2_loop_sel));
        ret(3);
        w(3);
        chk("tx bytes", 13, 16'(n_tx));
        wr(8'h0b, 8'h0c);
        center.frame(2, 0, 0, 0);
        w(40);
        chk("p2 sel", 2'b11, 16'(o_p2_loop_sel));
        chk("p2 bytes", 5, 16'(n_p2));
        rd(8'h49, 8'h01);
        @(posedge i_sys_clk) i_power_down_detect_n <= 1'b0;
        w(3);
        chk("ind count", 1, 16'(n_ind));
        chk("ind s0", 1, 16'(ind_st[0]));
        @(posedge i_sys_clk) i_diag_fail_in <= 1'b1;
        w(3);
        chk("ind count", 2, 16'(n_ind));
        chk("ind s3", 1, 16'(ind_st[3]));
        rst(5'b10000);
        center.cmd(1'b1);
        w(2);
        center.frame(3, 1, 0, 0);
        w(3);
        chk("p2 sel", 2'b10, 16'(o_p2_loop_sel));
        chk("p2 bytes", 8, 16'(n_p2));
        chk("p2 drop", 0, 16'(p2_drop));
        report_and_stop;
    end
endmodule
